//--- eedac_defines.svh
// Offsets, bit positions, reset values and timing of the data EEPROM access controller
`ifndef EEDAC_DEFINES_SVH
`define EEDAC_DEFINES_SVH
// Register offsets
`define EEDAC_OFS_FLAG 8'h0c
`define EEDAC_OFS_DATA 8'h9a
`define EEDAC_OFS_ADDR 8'h9b
`define EEDAC_OFS_CTRL 8'h9c
`define EEDAC_OFS_UNLOCK 8'h9d
// Bit positions
`define EEDAC_BIT_RD 0
`define EEDAC_BIT_WR 1
`define EEDAC_BIT_PERMIT 2
`define EEDAC_BIT_ABORT 3
`define EEDAC_BIT_DONE 7
// Values
`define EEDAC_RST_BYTE 8'h00
`define EEDAC_ERASED 8'hff
`define EEDAC_KEY1 8'h55
`define EEDAC_KEY2 8'haa
`define EEDAC_DEPTH 128
// Cycles from one sequence write to the next
`define EEDAC_SEQ_GAP 2
// Timing
`define EEDAC_CLK_NS 4
`define EEDAC_WRITE_NS 2000
`define EEDAC_WRITE_CYC ((`EEDAC_WRITE_NS + `EEDAC_CLK_NS - 1) / `EEDAC_CLK_NS)
`endif

//--- eedac_pkg.sv
// Types shared by the data EEPROM access controller
package eedac_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} eedac_wstate_e;
   typedef enum logic [1:0] {SQ_NONE, SQ_GOT55, SQ_GOTAA} eedac_seq_e;
   typedef struct packed {
      logic [7:0] data;
      logic [6:0] addr;
      logic rdReq;
      logic wrBusy;
      logic writePermit;
      logic writeAbortFlag;
      logic writeCompleteFlag;
      eedac_wstate_e wst;
      eedac_seq_e seq;
      logic [1:0] gap;
      logic [6:0] wAddr;
      logic [7:0] wData;
      logic rdPend;
      logic pgmPend;
      logic pgmProt;
      logic pgmAck;
      logic pgmDenied;
      logic [7:0] pgmData;
      logic [7:0] rdData;
   } eedac_state_s;
endpackage

//--- eedac_core_if.sv
// Array port and write timer port between the controller and its helpers
`timescale 1ns/1ns
interface eedac_core_if
#(
   parameter int AW = 7,
   parameter int DW = 8,
   parameter int TW = 10
);
   logic ce;
   logic memWe;
   logic memRe;
   logic [AW-1:0] memAddr;
   logic [DW-1:0] memWData;
   logic [DW-1:0] memRData;
   logic tmrStart;
   logic tmrStop;
   logic [TW-1:0] tmrLen;
   logic tmrDone;
   modport ctrl (output ce, memWe, memRe, memAddr, memWData, tmrStart, tmrStop, tmrLen,
                 input memRData, tmrDone);
   modport mem (input ce, memWe, memRe, memAddr, memWData, output memRData);
   modport tmr (input ce, tmrStart, tmrStop, tmrLen, output tmrDone);
endinterface

//--- eedac_mem.sv
// Byte array with registered read data
`timescale 1ns/1ns
`include "eedac_defines.svh"
module eedac_mem
#(
   parameter int DEPTH = `EEDAC_DEPTH,
   parameter int AW = 7,
   parameter int DW = 8
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Array port
   eedac_core_if.mem core
);
   import eedac_pkg::*;
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] cells;
      logic [DW-1:0] rdata;
   } eedac_mem_s;
   eedac_mem_s q, d;
   logic [DW-1:0] cellNow;

   assign cellNow = q.cells[core.memAddr];
   always_comb
   begin
      d = q;
      if (core.memWe)
         d.cells[core.memAddr] = core.memWData;
      if (core.memRe)
         d.rdata = cellNow;
   end

   // Contents are nonvolatile: reset touches only the read register
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         q.cells <= q.cells;
         q.rdata <= '0;
      end
      else if (core.ce)
         q <= d;
   end
   assign core.memRData = q.rdata;

   a_mem_read_reg: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
      core.ce && core.memRe && !core.memWe |=> core.memRData == $past(cellNow))
      else $error("array read data not registered from addressed cell");
endmodule

//--- eedac_timer.sv
// Down counter that times the erase and program phases
`timescale 1ns/1ns
module eedac_timer
#(
   parameter int TW = 10
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Timer port
   eedac_core_if.tmr core
);
   import eedac_pkg::*;
   typedef struct packed {
      logic [TW-1:0] cnt;
      logic run;
      logic done;
   } eedac_tmr_s;
   eedac_tmr_s q, d;

   always_comb
   begin
      d = q;
      d.done = 1'h0;
      if (core.tmrStop)
      begin
         d.run = 1'h0;
         d.cnt = '0;
      end
      else if (core.tmrStart)
      begin
         d.run = 1'h1;
         d.cnt = core.tmrLen;
      end
      else if (q.run)
      begin
         if (q.cnt <= TW'(1))
         begin
            d.run = 1'h0;
            d.done = 1'h1;
         end
         else
            d.cnt = q.cnt - TW'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         q <= '0;
      else if (core.ce)
         q <= d;
   end
   assign core.tmrDone = q.done;

   a_timer_load: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4]
      core.ce && core.tmrStart && !core.tmrStop |=> q.run && q.cnt == $past(core.tmrLen))
      else $error("write timer did not load its length");
endmodule

//--- eedac_top.sv
// Data EEPROM access controller: registers, unlock sequence, timed erase and program
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "eedac_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// [RULE1] 128-byte array, locations 0 to 7Fh
// [RULE2] Data register carries the byte
// [RULE3] Each write erases then programs
// [RULE4] On-chip timer sets write duration
// [RULE5] Protection blocks programmer, not CPU
// [RULE6] Address bit 7 ignored
// [RULE7] Software keeps address bit 7 zero
// [RULE8] Control upper nibble reads zero
// [RULE9] Triggers set by software, cleared by hardware
// [RULE10] Write permit gates array writes
// [RULE11] Write permit clear after power-up
// [RULE12] Reset during write sets abort flag
// [RULE13] Aborting reset clears data and address
// [RULE14] Completion sets flag; software clears it
// [RULE15] Unlock port unstored, reads zero
// [RULE16] Read data ready next cycle, held
// [RULE17] Exact 55h, AAh, trigger sequence starts write
// [RULE18] Write trigger refused without permit
// [RULE19] Dropping permit mid-write changes nothing
// [RULE20] Trigger stays set through timed write
// [RULE21] Reads wait until write finishes
////////////////////////////////////////////////////////////////////////////////
module eedac_top
#(
   parameter int WRITE_CYCLES = `EEDAC_WRITE_CYC
)
(
   // Clock, reset, freeze
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Device resets that abort a write
   input wire logic externalResetPin,
   input wire logic watchdogTimeout,
   // Programmer read port
   input wire logic dataProtect,
   input wire logic pgmReq,
   input wire logic [6:0] pgmAddr,
   output logic pgmAck,
   output logic pgmDenied,
   output logic [7:0] pgmData
);
   import eedac_pkg::*;
   localparam int TW = $clog2(WRITE_CYCLES + 1);
   localparam logic [TW-1:0] ERASE_LEN = TW'(WRITE_CYCLES / 2 - 1);
   localparam logic [TW-1:0] PROG_LEN = TW'(WRITE_CYCLES - WRITE_CYCLES / 2 - 1);
   localparam logic [1:0] SEQ_GAP = 2'(`EEDAC_SEQ_GAP);
   localparam eedac_state_s RST = '0;

   eedac_state_s q, d;
   logic abortRst;
   logic isUnlock;
   logic isCtrlWr;
   logic onTime;
   logic seqStep;
   logic startWrite;
   logic startRead;
   logic pgmTake;
   logic progEnd;

   eedac_core_if #(.AW(7), .DW(8), .TW(TW)) core ();

   eedac_mem #(.DEPTH(`EEDAC_DEPTH), .AW(7), .DW(8)) u_mem // [RULE1]
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .core(core)
   );

   eedac_timer #(.TW(TW)) u_timer
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .core(core)
   );

   assign core.ce = ce;
   assign abortRst = externalResetPin | watchdogTimeout;
   assign isUnlock = regWr && (regAddr == `EEDAC_OFS_UNLOCK);
   assign isCtrlWr = regWr && (regAddr == `EEDAC_OFS_CTRL);
   assign onTime = (q.gap == SEQ_GAP);

   ////////////////////////////////////////////////////////////////////////////////
   // Unlock sequence and operation starts
   always_comb
   begin
      case (q.seq)
         SQ_GOT55: seqStep = onTime && isUnlock && (regWrData == `EEDAC_KEY2); // [RULE17]
         SQ_GOTAA: seqStep = onTime && isCtrlWr && regWrData[`EEDAC_BIT_WR]; // [RULE17]
         default: seqStep = 1'h0;
      endcase
      // Permit is sampled before this write, so it cannot arm itself
      startWrite = seqStep && (q.seq == SQ_GOTAA) && q.writePermit // [RULE10] [RULE18]
                   && (q.wst == ST_IDLE) && !abortRst;
      startRead = (q.wst == ST_IDLE) && !startWrite && !abortRst // [RULE21]
                  && (q.rdReq || (isCtrlWr && regWrData[`EEDAC_BIT_RD]));
      pgmTake = pgmReq && !q.pgmPend && !q.pgmAck && (q.wst == ST_IDLE)
                && !startRead && !startWrite && !abortRst;
      progEnd = (q.wst == ST_PROG) && core.tmrDone && !abortRst;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Array and timer port
   always_comb
   begin
      core.memWe = startWrite || progEnd;
      core.memWData = startWrite ? `EEDAC_ERASED : q.wData; // [RULE3]
      core.memRe = startRead || (pgmTake && !dataProtect); // [RULE5]
      if (startWrite || startRead)
         core.memAddr = q.addr; // [RULE6]
      else if (q.wst != ST_IDLE)
         core.memAddr = q.wAddr;
      else
         core.memAddr = pgmAddr;
      core.tmrStart = startWrite || ((q.wst == ST_ERASE) && core.tmrDone && !abortRst); // [RULE4]
      core.tmrLen = startWrite ? ERASE_LEN : PROG_LEN;
      core.tmrStop = abortRst;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      d = q;
      d.rdData = `EEDAC_RST_BYTE;
      d.rdPend = startRead;
      d.pgmPend = pgmTake;
      d.pgmAck = q.pgmPend;
      d.pgmDenied = q.pgmPend & q.pgmProt;
      if (pgmTake)
         d.pgmProt = dataProtect;
      if (q.pgmPend)
         d.pgmData = q.pgmProt ? `EEDAC_RST_BYTE : core.memRData; // [RULE5]
      if (q.rdPend)
         d.data = core.memRData; // [RULE16]

      // Sequence: a missed slot or any stray access cancels it
      if (q.seq != SQ_NONE)
         d.gap = q.gap + 2'h1;
      if (seqStep)
      begin
         d.seq = (q.seq == SQ_GOT55) ? SQ_GOTAA : SQ_NONE;
         d.gap = 2'h1;
      end
      else if ((q.seq != SQ_NONE) && (onTime || regWr || regRd))
         d.seq = SQ_NONE; // [RULE17]
      if (isUnlock && (regWrData == `EEDAC_KEY1))
      begin
         d.seq = SQ_GOT55; // [RULE17]
         d.gap = 2'h1;
      end

      // Software writes; the unlock port stores nothing
      if (regWr)
      begin
         case (regAddr)
            `EEDAC_OFS_DATA: d.data = regWrData; // [RULE2]
            `EEDAC_OFS_ADDR: d.addr = regWrData[6:0]; // [RULE6]
            `EEDAC_OFS_CTRL:
            begin
               d.writePermit = regWrData[`EEDAC_BIT_PERMIT];
               d.writeAbortFlag = regWrData[`EEDAC_BIT_ABORT];
               if (regWrData[`EEDAC_BIT_RD])
                  d.rdReq = 1'h1; // [RULE9]
            end
            `EEDAC_OFS_FLAG: d.writeCompleteFlag = regWrData[`EEDAC_BIT_DONE]; // [RULE14]
            default: d.rdReq = d.rdReq;
         endcase
      end
      if (startRead)
         d.rdReq = 1'h0; // [RULE9]

      // Write phases; permit is not looked at once started
      case (q.wst)
         ST_IDLE:
         begin
            if (startWrite)
            begin
               d.wst = ST_ERASE;
               d.wrBusy = 1'h1;
               d.wAddr = q.addr;
               d.wData = q.data;
            end
         end
         ST_ERASE:
         begin
            if (core.tmrDone)
               d.wst = ST_PROG; // [RULE19]
         end
         ST_PROG:
         begin
            if (core.tmrDone)
            begin
               d.wst = ST_IDLE;
               d.wrBusy = 1'h0; // [RULE9] [RULE20]
               d.writeCompleteFlag = 1'h1; // [RULE14]
            end
         end
         default: d.wst = ST_IDLE;
      endcase

      // Register read, one cycle later; a fresh array read bypasses
      if (regRd)
      begin
         case (regAddr)
            `EEDAC_OFS_FLAG: d.rdData = {q.writeCompleteFlag, 7'h00};
            `EEDAC_OFS_DATA: d.rdData = q.rdPend ? core.memRData : q.data; // [RULE16]
            `EEDAC_OFS_ADDR: d.rdData = {1'h0, q.addr};
            `EEDAC_OFS_CTRL: d.rdData = {4'h0, q.writeAbortFlag, q.writePermit, q.wrBusy, q.rdReq}; // [RULE8]
            default: d.rdData = `EEDAC_RST_BYTE; // [RULE15]
         endcase
      end

      // Device reset other than power-up; the abort mark outlives it
      if (abortRst)
      begin
         d = RST; // [RULE13]
         d.writeAbortFlag = q.writeAbortFlag | (q.wst != ST_IDLE); // [RULE12]
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         q <= RST; // [RULE11]
      else if (ce)
         q <= d;
   end

   assign regRdData = q.rdData;
   assign pgmAck = q.pgmAck;
   assign pgmDenied = q.pgmDenied;
   assign pgmData = q.pgmData;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_read_issue: assert property (@(posedge clk_sys) disable iff (srst) // [RULE16]
      ce && startRead |-> core.memRe && core.memAddr == q.addr ##1 q.rdPend)
      else $error("read trigger did not reach the array");

   a_read_lands: assert property (@(posedge clk_sys) disable iff (srst) // [RULE16]
      ce && q.rdPend && !abortRst && !(regWr && regAddr == `EEDAC_OFS_DATA)
      |=> q.data == $past(core.memRData))
      else $error("read byte missing from data register");

   a_ctrl_upper: assert property (@(posedge clk_sys) disable iff (srst) // [RULE8]
      ce && regRd && regAddr == `EEDAC_OFS_CTRL |=> regRdData[7:4] == 4'h0)
      else $error("control upper nibble not zero");

   a_unlock_zero: assert property (@(posedge clk_sys) disable iff (srst) // [RULE15]
      ce && regRd && regAddr == `EEDAC_OFS_UNLOCK |=> regRdData == 8'h00)
      else $error("unlock port read not zero");

   a_permit_gate: assert property (@(posedge clk_sys) disable iff (srst) // [RULE18]
      ce && !q.writePermit && q.wst == ST_IDLE |=> q.wst == ST_IDLE && !q.wrBusy)
      else $error("write started without permit");

   a_busy_trigger: assert property (@(posedge clk_sys) disable iff (srst) // [RULE20]
      q.wst != ST_IDLE |-> q.wrBusy && !core.memRe)
      else $error("trigger dropped or read during write");

   a_erase_first: assert property (@(posedge clk_sys) disable iff (srst) // [RULE3]
      startWrite |-> core.memWe && core.memWData == 8'hff && core.tmrStart && core.tmrLen == ERASE_LEN)
      else $error("write did not begin with erase");

   a_write_done: assert property (@(posedge clk_sys) disable iff (srst) // [RULE14]
      ce && progEnd |-> core.memWe && core.memAddr == q.wAddr ##1 q.writeCompleteFlag && !q.wrBusy)
      else $error("write end did not program and flag");

   a_abort_mark: assert property (@(posedge clk_sys) disable iff (srst) // [RULE12]
      ce && abortRst && q.wst != ST_IDLE |=> q.writeAbortFlag && q.data == 8'h00 && q.addr == 7'h00)
      else $error("aborted write not recorded");

   a_prog_denied: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5]
      ce && pgmTake && dataProtect ##1 ce |=> pgmAck && pgmDenied && pgmData == 8'h00)
      else $error("protected array reached programmer");
endmodule

//--- data_eeprom_access_controller_tb_top.sv
// Self-checking testbench of the data EEPROM access controller
`timescale 1ns/1ns
`include "eedac_defines.svh"
module data_eeprom_access_controller_tb_top;
   // Short write time keeps the run brief
   localparam int WC = 8;
   localparam logic [7:0] FLG = `EEDAC_OFS_FLAG;
   localparam logic [7:0] DAT = `EEDAC_OFS_DATA;
   localparam logic [7:0] ADR = `EEDAC_OFS_ADDR;
   localparam logic [7:0] CTL = `EEDAC_OFS_CTRL;
   localparam logic [7:0] UNL = `EEDAC_OFS_UNLOCK;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic externalResetPin = 1'b0;
   logic watchdogTimeout = 1'b0;
   logic dataProtect = 1'b0;
   logic pgmReq = 1'b0;
   logic [6:0] pgmAddr = 7'h00;
   logic pgmAck;
   logic pgmDenied;
   logic [7:0] pgmData;
   int errors = 0;
   int comparisons = 0;

   eedac_top #(.WRITE_CYCLES(WC)) uut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .externalResetPin(externalResetPin), .watchdogTimeout(watchdogTimeout), .dataProtect(dataProtect),
      .pgmReq(pgmReq), .pgmAddr(pgmAddr), .pgmAck(pgmAck), .pgmDenied(pgmDenied), .pgmData(pgmData));

   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      v = regRdData;
   endtask

   task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(n, e, v);
   endtask

   // Consecutive calls of wr leave exactly one idle cycle, the gap the unlock needs
   task automatic startWrite(input logic [7:0] a, input logic [7:0] d);
      wr(ADR, a);
      wr(DAT, d);
      wr(CTL, 8'h04);
      wr(UNL, 8'h55);
      wr(UNL, 8'haa);
      wr(CTL, 8'h06);
   endtask

   task automatic waitIdle;
      logic [7:0] v;
      int n;
      n = 0;
      v = 8'h03;
      while (v[1:0] !== 2'b00 && n < 40)
      begin
         rd(CTL, v);
         n++;
      end
      comparisons++;
      if (n >= 40)
      begin
         errors++;
         $display("ERROR control idle expected 00 seen %h", v[1:0]);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdChk("data after reset", DAT, 8'h00);
      rdChk("address after reset", ADR, 8'h00);
      rdChk("control after reset", CTL, 8'h00);
      rdChk("unlock port", UNL, 8'h00);
      rdChk("flag after reset", FLG, 8'h00);
      rdChk("unmapped read", 8'h50, 8'h00);
   endtask

   task automatic t_write_read;
      startWrite(8'hff, 8'h5a);
      rdChk("trigger during write", CTL, 8'h06);
      rdChk("address bit 7 dropped", ADR, 8'h7f);
      waitIdle();
      rdChk("completion flag", FLG, 8'h80);
      wr(FLG, 8'h00);
      rdChk("flag cleared", FLG, 8'h00);
      wr(DAT, 8'h00);
      wr(CTL, 8'hf1);
      rdChk("read of top location", DAT, 8'h5a);
      rdChk("read byte held", DAT, 8'h5a);
      rdChk("upper control bits", CTL, 8'h00);
   endtask

   task automatic t_no_permit;
      wr(DAT, 8'ha5);
      wr(UNL, 8'h55);
      wr(UNL, 8'haa);
      wr(CTL, 8'h02);
      rdChk("trigger without permit", CTL, 8'h00);
      wr(CTL, 8'h01);
      rdChk("cell kept without permit", DAT, 8'h5a);
   endtask

   task automatic seqTry(input logic [7:0] k2, input bit gap);
      wr(DAT, 8'hc3);
      wr(CTL, 8'h04);
      wr(UNL, 8'h55);
      if (gap)
      begin
         @(posedge clk_sys);
      end
      wr(UNL, k2);
      wr(CTL, 8'h06);
      rdChk("trigger after broken unlock", CTL, 8'h04);
      wr(CTL, 8'h01);
      rdChk("cell kept after broken unlock", DAT, 8'h5a);
   endtask

   task automatic t_busy;
      startWrite(8'h10, 8'h3c);
      // Drops the permit, tries to clear the trigger and asks for a read at once
      wr(CTL, 8'h01);
      rdChk("control while busy", CTL, 8'h03);
      waitIdle();
      rdChk("read held off by write", DAT, 8'h3c);
      rdChk("flag after write", FLG, 8'h80);
      wr(FLG, 8'h00);
   endtask

   // A strobe while the clock enable is low must leave every register alone
   task automatic t_freeze;
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(DAT, 8'h99);
      ce <= 1'b1;
      rdChk("data kept while frozen", DAT, 8'h3c);
   endtask

   task automatic t_abort;
      for (int i = 0; i < 2; i++)
      begin
         startWrite(8'h20, 8'h77);
         @(posedge clk_sys);
         externalResetPin <= (i == 1);
         watchdogTimeout <= (i == 0);
         @(posedge clk_sys);
         externalResetPin <= 1'b0;
         watchdogTimeout <= 1'b0;
         rdChk("abort flag", CTL, 8'h08);
         rdChk("data after abort", DAT, 8'h00);
         rdChk("address after abort", ADR, 8'h00);
         wr(CTL, 8'h00);
         rdChk("abort flag cleared", CTL, 8'h00);
      end
   endtask

   task automatic t_prog;
      int n;
      for (int p = 0; p < 2; p++)
      begin
         @(posedge clk_sys);
         dataProtect <= p[0];
         pgmReq <= 1'b1;
         pgmAddr <= 7'h10;
         n = 0;
         do
         begin
            @(posedge clk_sys);
            #1;
            n++;
         end
         while (pgmAck !== 1'b1 && n < 20);
         chk("programmer ack", 8'h01, {7'h00, pgmAck});
         chk("programmer denied", {7'h00, p[0]}, {7'h00, pgmDenied});
         chk("programmer data", p ? 8'h00 : 8'h3c, pgmData);
         @(posedge clk_sys);
         pgmReq <= 1'b0;
         #1;
         chk("programmer ack pulse", 8'h00, {7'h00, pgmAck});
      end
      wr(ADR, 8'h10);
      wr(CTL, 8'h01);
      rdChk("protected read by cpu", DAT, 8'h3c);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Full run is well under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      $display("ERROR watchdog expected finish seen hang");
      results();
   end

   initial
   begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_write_read();
      t_no_permit();
      seqTry(8'haa, 1'b1);
      seqTry(8'ha5, 1'b0);
      t_busy();
      t_freeze();
      t_abort();
      t_prog();
      results();
   end
endmodule
